// File: design/ldim_defines.svh
`ifndef LDIM_DEFINES_SVH
`define LDIM_DEFINES_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define LDIM_CLK_MHZ       200
`define LDIM_PHI_LOSS_US   30000
`define LDIM_PHI_LOSS_CYC  (`LDIM_PHI_LOSS_US * `LDIM_CLK_MHZ)
`define LDIM_GSC_LOSS_US   100
`define LDIM_GSC_LOSS_CYC  (`LDIM_GSC_LOSS_US * `LDIM_CLK_MHZ)
`define LDIM_INT_TICK_NS   200
`define LDIM_INT_TICK_CYC  ((`LDIM_INT_TICK_NS * `LDIM_CLK_MHZ) / 1000)

// ----------------------------------------------------------------
// address map (byte offsets inside a device window)
// ----------------------------------------------------------------
`define LDIM_BCAST_BIT     12
`define LDIM_REG_CTRL      8'h00
`define LDIM_REG_GLOBAL    8'h04
`define LDIM_REG_TTHRESH   8'h08
`define LDIM_REG_DERATE    8'h0C
`define LDIM_REG_FAULT     8'h10
`define LDIM_REG_STATUS    8'h14
`define LDIM_REG_NVMCMD    8'h18
`define LDIM_REG_PACK0     8'h1C
`define LDIM_REG_PACK1     8'h80
`define LDIM_BANK_PW       3'h1
`define LDIM_BANK_PHASE    3'h2
`define LDIM_BANK_TRIM     3'h3

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define LDIM_CTRL_EXTDIRECT 0
`define LDIM_CTRL_DERATE    1
`define LDIM_CTRL_SYNCOFF   2
`define LDIM_CTRL_OPENOFF   3
`define LDIM_NVM_STORE      0
`define LDIM_NVM_RELOAD     1

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define LDIM_CFG_RST {4'h0, 6'h3F, 8'hC0, 6'h30, {8{8'hFF}}, {8{8'h00}}, {8{6'h3F}}}

`endif

// File: design/ldim_pkg.sv
package ldim_pkg;

  typedef struct packed {
    logic [3:0]      ctrl;
    logic [5:0]      globalIntensity;
    logic [7:0]      tempThresh;
    logic [5:0]      derate;
    logic [7:0][7:0] pw;
    logic [7:0][7:0] phase;
    logic [7:0][5:0] stringCurrentTrim;
  } ldim_cfg_t;

  typedef struct packed {
    logic [7:0] openStr;
    logic [7:0] shortLed;
    logic       syncLoss;
    logic       overTemp;
  } ldim_fault_t;

  typedef enum {
    LDIM_SEL_NONE, LDIM_SEL_CTRL, LDIM_SEL_GLOBAL, LDIM_SEL_TTHRESH,
    LDIM_SEL_DERATE, LDIM_SEL_FAULT, LDIM_SEL_STATUS, LDIM_SEL_NVMCMD,
    LDIM_SEL_PACK0, LDIM_SEL_PACK1, LDIM_SEL_PW, LDIM_SEL_PHASE, LDIM_SEL_TRIM
  } ldim_sel_t;

endpackage : ldim_pkg

// File: design/ldim_string_pwm.sv
`timescale 1ns/10ps
`default_nettype none
`include "ldim_defines.svh"

module ldim_string_pwm
  import ldim_pkg::*;
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       sys_rst,
  // frame timing
  input  wire logic       frameStart,
  input  wire logic [9:0] frameCnt,
  // settings
  input  wire logic [5:0] globalIntensity,
  input  wire logic [7:0] pw,
  input  wire logic [7:0] phase,
  input  wire logic [5:0] derate,
  input  wire logic       derateOn,
  // drive
  output logic            chanOn
);

  logic [9:0]  width;
  logic [9:0]  offset;
  logic [9:0]  next_width;
  logic [9:0]  next_offset;
  logic [13:0] product;
  logic [15:0] derated;
  logic [9:0]  effWidth;
  logic [9:0]  pos;

  // ----------------------------------------------------------------
  // width and phase
  // ----------------------------------------------------------------
  always_comb begin
    product  = 14'(globalIntensity * pw);
    effWidth = product[13:4];
    derated  = 16'(effWidth * derate);
    if (derateOn) begin
      effWidth = derated[15:6];
    end
    next_width  = width;
    next_offset = offset;
    if (frameStart) begin
      next_width  = effWidth;
      next_offset = {phase, 2'b00};
    end
    pos = 10'(frameCnt - offset);
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      width  <= 10'h000;
      offset <= 10'h000;
      chanOn <= 1'b0;
    end else begin
      width  <= next_width;
      offset <= next_offset;
      chanOn <= (pos < width);
    end
  end

endmodule : ldim_string_pwm
`default_nettype wire

// File: design/ldim_engine.sv
// Contract
// - 6-bit global intensity scales all strings
// - 8-bit pulse width per string
// - 10-bit effective width from global and string
// - 6-bit per-string current trim output
// - external pwm input as global alternative
// - internal engine or direct external drive
// - derate on time above temperature threshold
// - derating is one 6-bit factor shared by all strings
// - frame aligns period, gate clock steps
// - programmable phase offset per string
// - detect sync loss, optionally blank strings
// - faults assert active-low fault output
// - fault status and control via registers
// - all eight widths rewritten in two packed writes
// - own address plus broadcast, sixteen devices
// - defaults load from rewritable non-volatile store
// - fault output held until read or disable
// - gate clock up to 5MHz sets step
`timescale 1ns/10ps
`default_nettype none
`include "ldim_defines.svh"

module ldim_engine
  import ldim_pkg::*;
#(
  parameter int PHI_LOSS_CYC = `LDIM_PHI_LOSS_CYC,
  parameter int GSC_LOSS_CYC = `LDIM_GSC_LOSS_CYC
) (
  // clock and reset
  input  wire logic            clock,
  input  wire logic            sys_rst,
  // apb slave
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [31:0]     paddr,
  input  wire logic [31:0]     pwdata,
  output logic [31:0]          prdata,
  output logic                 pready,
  output logic                 pslverr,
  // pins from outside
  input  wire logic            framePhaseSyncIn,
  input  wire logic            pixelGateShiftClockIn,
  input  wire logic            extPwmIn,
  input  wire logic            enableIn,
  input  wire logic [1:0]      slaveAddrSel0,
  input  wire logic [1:0]      slaveAddrSel1,
  input  wire logic [7:0]      stringOpenSense,
  input  wire logic [7:0]      ledShortSense,
  input  wire logic            dieHotIn,
  input  wire logic [7:0]      ledTempCode,
  // string drive
  output logic [7:0]           stringGate,
  output logic [7:0][5:0]      stringCurrentTrim,
  // open-drain fault pin
  output logic                 faultOutNOut,
  output logic                 faultOutNOe
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [32:0] syncA;
  logic [32:0] syncB;
  logic        phaseS;
  logic        gscS;
  logic        extPwmS;
  logic        enableS;
  logic [3:0]  devId;
  logic [7:0]  openS;
  logic [7:0]  shortS;
  logic        dieHotS;
  logic [7:0]  tempS;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      syncA <= 33'h0_0000_0000;
      syncB <= 33'h0_0000_0000;
    end else begin
      syncA <= {framePhaseSyncIn, pixelGateShiftClockIn, extPwmIn, enableIn,
                slaveAddrSel1, slaveAddrSel0, stringOpenSense, ledShortSense,
                dieHotIn, ledTempCode};
      syncB <= syncA;
    end
  end

  assign {phaseS, gscS, extPwmS, enableS, devId, openS, shortS, dieHotS, tempS} = syncB;

  // ----------------------------------------------------------------
  // frame and step timing
  // ----------------------------------------------------------------
  logic        prevPhase;
  logic        prevGsc;
  logic [23:0] phiLossCnt;
  logic [23:0] gscLossCnt;
  logic [7:0]  intTickCnt;
  logic [9:0]  frameCnt;
  logic        next_prevPhase;
  logic        next_prevGsc;
  logic [23:0] next_phiLossCnt;
  logic [23:0] next_gscLossCnt;
  logic [7:0]  next_intTickCnt;
  logic [9:0]  next_frameCnt;
  logic        phaseEdge;
  logic        gscEdge;
  logic        phaseLost;
  logic        gscLost;
  logic        intTick;
  logic        tick;
  logic        frameStart;

  always_comb begin
    next_prevPhase = phaseS;
    next_prevGsc   = gscS;
    phaseEdge = phaseS & ~prevPhase;
    gscEdge   = gscS & ~prevGsc;
    phaseLost = (phiLossCnt == 24'(PHI_LOSS_CYC));
    gscLost   = (gscLossCnt == 24'(GSC_LOSS_CYC));
    next_phiLossCnt = phaseEdge ? 24'h00_0000 :
                      (phaseLost ? phiLossCnt : 24'(phiLossCnt + 24'h1));
    next_gscLossCnt = gscEdge ? 24'h00_0000 :
                      (gscLost ? gscLossCnt : 24'(gscLossCnt + 24'h1));
    intTick = (intTickCnt == 8'(`LDIM_INT_TICK_CYC - 1));
    next_intTickCnt = intTick ? 8'h00 : 8'(intTickCnt + 8'h1);
    tick = gscEdge | (gscLost & intTick);
    frameStart = phaseEdge | (phaseLost & tick & (frameCnt == 10'h3FF));
    next_frameCnt = frameCnt;
    if (frameStart) begin
      next_frameCnt = 10'h000;
    end else if (tick) begin
      next_frameCnt = 10'(frameCnt + 10'h1);
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      prevPhase  <= 1'b0;
      prevGsc    <= 1'b0;
      phiLossCnt <= 24'h00_0000;
      gscLossCnt <= 24'h00_0000;
      intTickCnt <= 8'h00;
      frameCnt   <= 10'h000;
    end else begin
      prevPhase  <= next_prevPhase;
      prevGsc    <= next_prevGsc;
      phiLossCnt <= next_phiLossCnt;
      gscLossCnt <= next_gscLossCnt;
      intTickCnt <= next_intTickCnt;
      frameCnt   <= next_frameCnt;
    end
  end

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  function automatic ldim_sel_t decodeSel(input logic [7:0] a);
    ldim_sel_t s;
    s = LDIM_SEL_NONE;
    if (a == `LDIM_REG_CTRL) s = LDIM_SEL_CTRL;
    else if (a == `LDIM_REG_GLOBAL) s = LDIM_SEL_GLOBAL;
    else if (a == `LDIM_REG_TTHRESH) s = LDIM_SEL_TTHRESH;
    else if (a == `LDIM_REG_DERATE) s = LDIM_SEL_DERATE;
    else if (a == `LDIM_REG_FAULT) s = LDIM_SEL_FAULT;
    else if (a == `LDIM_REG_STATUS) s = LDIM_SEL_STATUS;
    else if (a == `LDIM_REG_NVMCMD) s = LDIM_SEL_NVMCMD;
    else if (a == `LDIM_REG_PACK0) s = LDIM_SEL_PACK0;
    else if (a == `LDIM_REG_PACK1) s = LDIM_SEL_PACK1;
    else if (a[1:0] == 2'b00 && a[7:5] == `LDIM_BANK_PW) s = LDIM_SEL_PW;
    else if (a[1:0] == 2'b00 && a[7:5] == `LDIM_BANK_PHASE) s = LDIM_SEL_PHASE;
    else if (a[1:0] == 2'b00 && a[7:5] == `LDIM_BANK_TRIM) s = LDIM_SEL_TRIM;
    return s;
  endfunction : decodeSel

  // ----------------------------------------------------------------
  // apb slave, configuration and fault state
  // ----------------------------------------------------------------
  ldim_cfg_t   cfg;
  ldim_cfg_t   nvm;
  ldim_fault_t fault;
  logic        loadPending;
  logic        ackd;
  ldim_cfg_t   next_cfg;
  ldim_cfg_t   next_nvm;
  ldim_fault_t next_fault;
  logic        next_loadPending;
  logic        next_ackd;
  logic [31:0] next_prdata;
  logic        next_pslverr;
  logic        next_faultOe;
  ldim_sel_t   sel;
  logic [2:0]  idx;
  logic        bcast;
  logic        own;
  logic        badAddr;
  logic        wrEn;
  logic        rdClear;
  logic        tempHot;
  logic        syncBlank;
  logic [7:0]  chanOn;
  logic [7:0]  next_gate;
  logic [31:0] rdVal;
  ldim_fault_t evt;

  assign pready = psel & penable & ackd;

  always_comb begin
    sel   = decodeSel(paddr[7:0]);
    idx   = paddr[4:2];
    bcast = paddr[`LDIM_BCAST_BIT];
    own   = ~bcast & (paddr[11:8] == devId);
    badAddr = (paddr[31:13] != 19'h0_0000) | (sel == LDIM_SEL_NONE) |
              ~(own | (bcast & pwrite));
    wrEn    = pready & pwrite & ~badAddr;
    rdClear = pready & ~pwrite & ~badAddr & (sel == LDIM_SEL_FAULT);
    tempHot = (tempS > cfg.tempThresh);
    rdVal = 32'h0000_0000;
    unique case (sel)
      LDIM_SEL_CTRL:    rdVal[3:0] = cfg.ctrl;
      LDIM_SEL_GLOBAL:  rdVal[5:0] = cfg.globalIntensity;
      LDIM_SEL_TTHRESH: rdVal[7:0] = cfg.tempThresh;
      LDIM_SEL_DERATE:  rdVal[5:0] = cfg.derate;
      LDIM_SEL_FAULT:   rdVal[17:0] = fault;
      LDIM_SEL_STATUS:  rdVal[15:0] = {frameCnt, tempHot, loadPending,
                                       gscLost, phaseLost, enableS, dieHotS};
      LDIM_SEL_PACK0:   rdVal = {cfg.pw[3], cfg.pw[2], cfg.pw[1], cfg.pw[0]};
      LDIM_SEL_PACK1:   rdVal = {cfg.pw[7], cfg.pw[6], cfg.pw[5], cfg.pw[4]};
      LDIM_SEL_PW:      rdVal[7:0] = cfg.pw[idx];
      LDIM_SEL_PHASE:   rdVal[7:0] = cfg.phase[idx];
      LDIM_SEL_TRIM:    rdVal[5:0] = cfg.stringCurrentTrim[idx];
      default:          rdVal = 32'h0000_0000;
    endcase
    next_ackd    = psel & penable & ~ackd;
    next_prdata  = (next_ackd & ~pwrite & ~badAddr) ? rdVal : 32'h0000_0000;
    next_pslverr = next_ackd & badAddr;
    // configuration and non-volatile copy
    next_cfg         = loadPending ? nvm : cfg;
    next_nvm         = nvm;
    next_loadPending = 1'b0;
    if (wrEn) begin
      unique case (sel)
        LDIM_SEL_CTRL:    next_cfg.ctrl = pwdata[3:0];
        LDIM_SEL_GLOBAL:  next_cfg.globalIntensity = pwdata[5:0];
        LDIM_SEL_TTHRESH: next_cfg.tempThresh = pwdata[7:0];
        LDIM_SEL_DERATE:  next_cfg.derate = pwdata[5:0];
        LDIM_SEL_PACK0:   next_cfg.pw[3:0] = pwdata;
        LDIM_SEL_PACK1:   next_cfg.pw[7:4] = pwdata;
        LDIM_SEL_PW:      next_cfg.pw[idx] = pwdata[7:0];
        LDIM_SEL_PHASE:   next_cfg.phase[idx] = pwdata[7:0];
        LDIM_SEL_TRIM:    next_cfg.stringCurrentTrim[idx] = pwdata[5:0];
        LDIM_SEL_NVMCMD: begin
          if (pwdata[`LDIM_NVM_STORE]) begin
            next_nvm = cfg;
          end
          if (pwdata[`LDIM_NVM_RELOAD]) begin
            next_loadPending = 1'b1;
          end
        end
        default: next_cfg = next_cfg;
      endcase
    end
    // fault events, set wins over clear
    syncBlank = cfg.ctrl[`LDIM_CTRL_SYNCOFF] & (phaseLost | gscLost);
    evt.openStr  = openS & stringGate;
    evt.shortLed = shortS & stringGate;
    evt.syncLoss = phaseLost | gscLost;
    evt.overTemp = dieHotS;
    next_fault = (enableS ? fault & ~(prdata[17:0] & {18{rdClear}}) : 18'h0) | evt;
    next_faultOe = |next_fault;
    for (int i = 0; i < 8; i++) begin
      next_gate[i] = enableS & ~syncBlank &
                     ~(cfg.ctrl[`LDIM_CTRL_OPENOFF] & fault.openStr[i]) &
                     (cfg.ctrl[`LDIM_CTRL_EXTDIRECT] ? extPwmS : chanOn[i]);
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cfg         <= `LDIM_CFG_RST;
      nvm         <= `LDIM_CFG_RST;
      fault       <= 18'h0_0000;
      loadPending <= 1'b1;
      ackd        <= 1'b0;
      prdata      <= 32'h0000_0000;
      pslverr     <= 1'b0;
      faultOutNOe <= 1'b0;
      stringGate  <= 8'h00;
    end else begin
      cfg         <= next_cfg;
      nvm         <= next_nvm;
      fault       <= next_fault;
      loadPending <= next_loadPending;
      ackd        <= next_ackd;
      prdata      <= next_prdata;
      pslverr     <= next_pslverr;
      faultOutNOe <= next_faultOe;
      stringGate  <= next_gate;
    end
  end

  assign faultOutNOut      = 1'b0;
  assign stringCurrentTrim = cfg.stringCurrentTrim;

  // ----------------------------------------------------------------
  // per-string pulse engines
  // ----------------------------------------------------------------
  for (genvar g = 0; g < 8; g++) begin : gStr
    ldim_string_pwm uPwm (
      .clock           (clock),
      .sys_rst         (sys_rst),
      .frameStart      (frameStart),
      .frameCnt        (frameCnt),
      .globalIntensity (cfg.globalIntensity),
      .pw              (cfg.pw[g]),
      .phase           (cfg.phase[g]),
      .derate          (cfg.derate),
      .derateOn        (cfg.ctrl[`LDIM_CTRL_DERATE] & tempHot),
      .chanOn          (chanOn[g])
    );
  end

endmodule : ldim_engine
`default_nettype wire

// File: tb/ldim_engine_monitor.sv
`timescale 1ns/10ps
`default_nettype none

module ldim_engine_monitor
  import ldim_pkg::*;
(
  // clock and reset
  input wire logic            clock,
  input wire logic            sys_rst,
  // apb
  input wire logic            psel,
  input wire logic            penable,
  input wire logic            pwrite,
  input wire logic [31:0]     prdata,
  input wire logic            pready,
  input wire logic            pslverr,
  // pins
  input wire logic            enableIn,
  input wire logic [7:0]      stringGate,
  input wire logic [7:0][5:0] stringCurrentTrim,
  input wire logic            faultOutNOut,
  input wire logic            faultOutNOe
);
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held past one cycle");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("pready outside an access phase");
  a_one_wait: assert property ((psel && !penable) ##1 (psel && penable) |-> !pready ##1 pready)
    else $error("access did not end after one wait state");
  a_pin_sinks: assert property (faultOutNOut == 1'b0)
    else $error("fault pin drives high");
  a_enable_blank: assert property (!enableIn [*6] |-> stringGate == 8'h00)
    else $error("strings driven while disabled");
  a_fault_hold: assert property (faultOutNOe && $past(enableIn, 2)
    && !(pready && !pwrite) |=> faultOutNOe)
    else $error("fault output released without read or disable");
  a_trim_stable: assert property (!(pready && pwrite) && !$past(pready && pwrite)
    && !$past(pready && pwrite, 2) |=> $stable(stringCurrentTrim))
    else $error("trim changed without a write");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr outside a response");
  a_err_zero: assert property (pready && pslverr |-> prdata == 32'h0)
    else $error("refused access returned data");
endmodule : ldim_engine_monitor

bind ldim_engine ldim_engine_monitor i_ldim_engine_monitor (
  .clock, .sys_rst, .psel, .penable, .pwrite, .prdata, .pready, .pslverr,
  .enableIn, .stringGate, .stringCurrentTrim, .faultOutNOut, .faultOutNOe
);

`default_nettype wire

// File: tb/ldim_link_partner.sv
`timescale 1ns/10ps
`default_nettype none

module ldim_link_partner
  import ldim_pkg::*;
(
  // frame and step pins
  output logic framePhaseSyncIn,
  output logic pixelGateShiftClockIn
);
  // ----------------------------------------------------------------
  // frame source, step clock stands still between frames
  // ----------------------------------------------------------------
  initial begin
    framePhaseSyncIn = 1'b0;
    pixelGateShiftClockIn = 1'b0;
  end

  // frame rate scaled with the shortened loss timer
  task automatic run_frame(input int steps);
    #1.3 framePhaseSyncIn = 1'b1;
    #40 framePhaseSyncIn = 1'b0;
    #40;
    repeat (steps) begin
      pixelGateShiftClockIn = 1'b1;
      #32 pixelGateShiftClockIn = 1'b0;
      #32;
    end
  endtask : run_frame
endmodule : ldim_link_partner

`default_nettype wire

// File: tb/led_string_pwm_dimming_engine_tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module led_string_pwm_dimming_engine_tb_top
  import ldim_pkg::*;
;
  localparam logic [31:0] OWN_BASE = 32'h0000_0900;
  logic            clock = 1'b0;
  logic            sys_rst = 1'b1;
  logic            psel = 1'b0;
  logic            penable = 1'b0;
  logic            pwrite = 1'b0;
  logic [31:0]     paddr = 32'h0;
  logic [31:0]     pwdata = 32'h0;
  logic [31:0]     prdata;
  logic            pready;
  logic            pslverr;
  wire logic       framePhaseSyncIn;
  wire logic       pixelGateShiftClockIn;
  logic            extPwmIn = 1'b0;
  logic            enableIn = 1'b1;
  logic [1:0]      slaveAddrSel0 = 2'h1;
  logic [1:0]      slaveAddrSel1 = 2'h2;
  logic [7:0]      stringOpenSense = 8'h00;
  logic [7:0]      ledShortSense = 8'h00;
  logic            dieHotIn = 1'b0;
  logic [7:0]      ledTempCode = 8'h00;
  logic [7:0]      stringGate;
  logic [7:0][5:0] stringCurrentTrim;
  logic            faultOutNOut;
  logic            faultOutNOe;
  wire logic       faultPinN = faultOutNOe ? faultOutNOut : 1'b1;
  int              err_total = 0;
  int              samples_checked = 0;
  int              cyc = 0;
  int              seed = 32'h18E69540;
  int              hi[8];
  int              pw[8];
  int              ph[8];
  int              g, d, w, e;
  bit              meas = 1'b0;
  logic [31:0]     rd;
  logic            er;
  int              rstOff[7] = '{32'h00, 32'h04, 32'h08, 32'h0C, 32'h20, 32'h40, 32'h7C};
  logic [31:0]     rstVal[7] = '{32'h0, 32'h3F, 32'hC0, 32'h30, 32'hFF, 32'h0, 32'h3F};
  logic [31:0]     badAdr[4] = '{32'h9FC, 32'h504, 32'h1004, 32'h8000_0904};

  ldim_engine #(.PHI_LOSS_CYC(2000), .GSC_LOSS_CYC(200)) i_ldim_engine (
    .clock, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .framePhaseSyncIn, .pixelGateShiftClockIn, .extPwmIn, .enableIn,
    .slaveAddrSel0, .slaveAddrSel1, .stringOpenSense, .ledShortSense, .dieHotIn,
    .ledTempCode, .stringGate, .stringCurrentTrim, .faultOutNOut, .faultOutNOe
  );
  ldim_link_partner i_ldim_link_partner (.framePhaseSyncIn, .pixelGateShiftClockIn);

  // ----------------------------------------------------------------
  // clock, timeout, step sampling, bus tasks
  // ----------------------------------------------------------------
  always #2.5 clock = ~clock;

  always @(posedge clock) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      report_and_stop();
    end
  end

  always @(posedge pixelGateShiftClockIn) begin
    if (meas) begin
      for (int i = 0; i < 8; i++) if (stringGate[i] === 1'b1) hi[i]++;
    end
  end

  task report_and_stop();
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop

  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_val

  task automatic cmp_cnt(input int got, input int exp);
    samples_checked++;
    if (got != exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_cnt

  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] dt,
                     output logic [31:0] rdat, output logic err);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= dt;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input int off, input logic [31:0] dt);
    apb(1'b1, OWN_BASE + off, dt, rd, er);
  endtask : wr

  task automatic rdc(input int off, input logic [31:0] exp, input logic [31:0] mask);
    apb(1'b0, OWN_BASE + off, 32'h0, rd, er);
    cmp_val(rd & mask, exp);
  endtask : rdc

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clock);
    foreach (rstOff[j]) rdc(rstOff[j], rstVal[j], 32'hFFFF_FFFF);
    @(negedge clock);
    cmp_val({26'h0, stringCurrentTrim[7]}, 32'h3F);
    foreach (badAdr[j]) begin
      apb(1'b0, badAdr[j], 32'h0, rd, er);
      cmp_val({rd[30:0], er}, 32'h1);
    end
    apb(1'b1, 32'h1004, 32'h15, rd, er);
    rdc(32'h04, 32'h15, 32'hFFFF_FFFF);
    wr(32'h6C, 32'h2A);
    @(negedge clock);
    cmp_val({26'h0, stringCurrentTrim[3]}, 32'h2A);
    wr(32'h04, 32'h2A);
    wr(32'h18, 32'h1);
    wr(32'h04, 32'h05);
    wr(32'h18, 32'h2);
    repeat (4) @(posedge clock);
    rdc(32'h04, 32'h2A, 32'hFFFF_FFFF);
    i_ldim_link_partner.run_frame(128);
    for (int k = 0; k < 3; k++) begin
      @(posedge clock);
      ledTempCode <= (k == 1) ? 8'hC0 : 8'hC1;
      g = $random(seed) & 63;
      d = $random(seed) & 63;
      for (int i = 0; i < 8; i++) begin
        pw[i] = $random(seed) & 255;
        ph[i] = $random(seed) & 255;
        hi[i] = 0;
        wr(32'h40 + 4 * i, ph[i]);
      end
      wr(32'h00, k ? 32'h2 : 32'h0);
      wr(32'h04, g);
      wr(32'h0C, d);
      wr(32'h1C, {pw[3][7:0], pw[2][7:0], pw[1][7:0], pw[0][7:0]});
      wr(32'h80, {pw[7][7:0], pw[6][7:0], pw[5][7:0], pw[4][7:0]});
      meas = 1'b1;
      fork
        i_ldim_link_partner.run_frame(128);
        begin
          repeat (300) @(posedge clock);
          wr(32'h1C, $random(seed));
          wr(32'h80, $random(seed));
        end
      join
      meas = 1'b0;
      for (int i = 0; i < 8; i++) begin
        w = (g * pw[i]) >> 4;
        if (k == 2) w = (w * d) >> 6;
        e = 0;
        for (int c = 0; c < 128; c++) if (((c - ph[i] * 4) & 1023) < w) e++;
        cmp_cnt(hi[i], e);
      end
    end
    wr(32'h00, 32'h1);
    extPwmIn <= 1'b1;
    fork
      i_ldim_link_partner.run_frame(128);
      begin
        apb(1'b0, OWN_BASE + 32'h10, 32'h0, rd, er);
        ledShortSense <= 8'h04;
        dieHotIn <= 1'b1;
        repeat (8) @(posedge clock);
        ledShortSense <= 8'h00;
        dieHotIn <= 1'b0;
        repeat (8) @(negedge clock);
        cmp_val({24'h0, stringGate}, 32'hFF);
        cmp_val({31'h0, faultPinN}, 32'h0);
        rdc(32'h10, 32'h11, 32'h3FD);
        repeat (2) @(negedge clock);
        cmp_val({31'h0, faultPinN}, 32'h1);
        @(posedge clock);
        dieHotIn <= 1'b1;
        repeat (8) @(posedge clock);
        dieHotIn <= 1'b0;
        enableIn <= 1'b0;
        repeat (8) @(negedge clock);
        cmp_val({23'h0, stringGate, faultPinN}, 32'h1);
        @(posedge clock);
        enableIn <= 1'b1;
        extPwmIn <= 1'b0;
        repeat (8) @(negedge clock);
        cmp_val({24'h0, stringGate}, 32'h0);
      end
    join
    wr(32'h00, 32'h9);
    stringOpenSense <= 8'h20;
    extPwmIn <= 1'b1;
    repeat (8) @(negedge clock);
    cmp_val({24'h0, stringGate}, 32'hDF);
    rdc(32'h10, 32'h8000, 32'h3FC00);
    stringOpenSense <= 8'h00;
    wr(32'h00, 32'h5);
    extPwmIn <= 1'b1;
    repeat (2500) @(negedge clock);
    cmp_val({24'h0, stringGate}, 32'h0);
    rdc(32'h10, 32'h2, 32'h2);
    report_and_stop();
  end
endmodule : led_string_pwm_dimming_engine_tb_top

`default_nettype wire
